// [verilog/screw_monitor_consts.vh]
/*
 * Constants of the second screw tracking monitor: register offsets,
 * field positions, fault patterns and tracking limits.
 * Assumes inclusion by its bare name from the monitor module.
 */
`ifndef SCREW_MONITOR_CONSTS_VH
`define SCREW_MONITOR_CONSTS_VH

// Register byte offsets
`define REG_CONTROL 8'h00
`define REG_STATE 8'h04
`define REG_FAULT_STATUS 8'h08
`define REG_MOTION_COUNT 8'h0c
`define REG_LARGE_COUNT 8'h10
`define REG_IRQ_STATUS 8'h14
`define REG_IRQ_MASK 8'h18

// Control register fields
`define CTRL_SCREW_IGNORE 0
`define CTRL_SOFT_RESET 1

// State register fields
`define STATE_SECOND_CHANCE 0
`define STATE_LARGE_STEP 1
`define STATE_CMD_BLOCK 2

// Interrupt status fields
`define IRQ_TRACK_FAULT 0
`define IRQ_LARGE_STEP 1
`define IRQ_OVERRUN_FAULT 2
`define IRQ_PHASE_CHANGE 3
`define IRQ_WIDTH 4

// Sensor phase bit value within the discretes byte
`define PHASE_MASK 8'h20

// Fault patterns merged into the fault status word
`define TRACK_FAULT_BITS 16'h8200
`define OVERRUN_FAULT_BITS 16'h0a00

// Tracking limits: step and motion in 16-bit position counts, large steps as an 8-bit pass count
`define STEP_LIMIT 16'h000c
`define MOTION_LIMIT 16'h0032
`define LARGE_STEP_MAX 8'h0a

// Reset values
`define FAULT_RESET 16'h0000
`define IRQ_MASK_RESET 4'h0

`endif

// [verilog/second_screw_tracking_monitor.v]
/*
 * Second screw tracking monitor. Once per evaluation pass it samples the
 * rotation sensor phase and the focus position, accumulates motion within
 * each sensor state, filters large steps and shuts the drive down when the
 * tracking tolerance is exceeded. Registers sit on a plain strobe port.
 * Tracking registers take their next values from one combinational
 * block; sticky interrupt flags are built one per event bit.
 * Assumes pass strobe, discretes and position are synchronous to i_clock,
 * and that the drive logic outside acts on the shutdown pulse.
 */
// Function
// R1 - Phase change clears motion count; nothing else tracked that pass.
// R2 - Without phase change, step is saved position minus current position.
// R3 - Step within plus or minus 12 is smooth and clears large-step flag.
// R4 - Step beyond plus or minus 12 sets large-step flag.
// R5 - Positions are 14-bit values shifted left into 16 bits.
// R6 - Smooth pass adds the step to the motion count.
// R7 - Each analysed pass saves its step as previous step; code saves only smooth steps, a large step keeps the old one.
// R8 - Each analysed pass saves current position for the next pass; code skips this on phase-change and overrun passes.
// R9 - Motion count reaching plus or minus 50 is a tracking fault.
// R10 - Tracking fault merges 8200H into the fault status word.
// R11 - Tracking fault sets second-chance flag and shuts the drive down.
// R12 - Every large-step pass increments the large-step counter.
// R13 - Counter equal to 10 merges 0A00H and shuts the drive down.
// R14 - Counter below 10 adds previous step instead; pass finishes normally.
// R15 - About ten passes per sensor state at full drive rate.
// R16 - Screw-ignore flag skips phase and tracking analysis.
// R17 - Phase is bit value 32 of discretes, compared by exclusive-or.
// R18 - Failure with second chance set blocks later position commands.
// R19 - Reset clears all tracking state and the second-chance flag.
`timescale 1ns/1ps
`include "screw_monitor_consts.vh"

module second_screw_tracking_monitor (
	input wire i_clock,
	input wire i_reset_n,
	input wire i_eval_pass,
	input wire [7:0] i_discretes,
	input wire [15:0] i_position,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_write,
	input wire i_read,
	output reg [31:0] o_rdata,
	output reg o_drive_shutdown,
	output reg o_cmd_block,
	output wire o_irq
);

	reg reset_meta_n;
	reg reset_n;
	reg screw_ignore_flag;
	reg sensor_phase_sample;
	reg [15:0] in_state_motion_count;
	reg [15:0] prev_in_state_position;
	reg [15:0] prev_step_value;
	reg large_step_flag;
	reg [7:0] large_step_counter;
	reg second_chance_flag;
	reg [15:0] fault_status_word;
	wire [`IRQ_WIDTH-1:0] irq_status;
	reg [`IRQ_WIDTH-1:0] irq_mask;

	wire soft_reset;
	wire control_write;
	wire mask_write;
	wire irq_clear;
	wire [15:0] current_position;
	wire phase_now;
	wire phase_changed;
	wire [15:0] step;
	wire step_small;
	wire step_not_above;
	wire step_not_below;
	wire [7:0] next_large_count;
	wire overrun;
	wire [15:0] addend;
	wire [15:0] next_motion_count;
	wire bound_exceeded_flag;
	wire count_high;
	wire count_low;
	wire analyse;
	wire track_fault;
	wire overrun_fault;
	wire [`IRQ_WIDTH-1:0] irq_events;
	reg [31:0] next_rdata;
	reg next_sensor_phase_sample;
	reg [15:0] next_in_state_motion_count;
	reg [15:0] next_prev_in_state_position;
	reg [15:0] next_prev_step_value;
	reg next_large_step_flag;
	reg [7:0] next_large_step_counter;
	reg next_second_chance_flag;
	reg [15:0] next_fault_status_word;
	reg next_cmd_block;
	reg next_drive_shutdown;

	// Reset release through two flip-flops
	always @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			reset_meta_n <= 1'b0;
			reset_n <= 1'b0;
		end else begin
			reset_meta_n <= 1'b1;
			reset_n <= reset_meta_n;
		end
	end

	// Register write decode and soft reset pulse
	assign control_write = i_write && (i_addr == `REG_CONTROL);
	assign mask_write = i_write && (i_addr == `REG_IRQ_MASK);
	assign irq_clear = i_write && (i_addr == `REG_IRQ_STATUS);
	assign soft_reset = control_write && i_wdata[`CTRL_SOFT_RESET];

	// Position word arrives already shifted; limits are in 16-bit units
	assign current_position = i_position; // R5
	assign phase_now = |(i_discretes & `PHASE_MASK); // R17
	assign phase_changed = phase_now ^ sensor_phase_sample; // R17
	assign analyse = i_eval_pass && !screw_ignore_flag; // R16

	// Step and its symmetric bound test
	assign step = prev_in_state_position - current_position; // R2
	assign step_not_above = $signed(step) <= $signed(`STEP_LIMIT); // R3
	assign step_not_below = $signed(step) >= -$signed(`STEP_LIMIT); // R3
	assign step_small = step_not_above && step_not_below; // R3

	// Large-step counting and overrun test
	assign next_large_count = large_step_counter + 8'h01; // R12
	assign overrun = !step_small &&
		(next_large_count == `LARGE_STEP_MAX); // R13

	// Substitute the previous step for a questionable one
	assign addend = step_small ? step : prev_step_value; // R14
	assign next_motion_count = in_state_motion_count + addend; // R6 R15
	assign count_high =
		$signed(next_motion_count) >= $signed(`MOTION_LIMIT); // R9
	assign count_low =
		$signed(next_motion_count) <= -$signed(`MOTION_LIMIT); // R9
	assign bound_exceeded_flag = count_high || count_low; // R9

	// Fault events of this pass
	assign overrun_fault = analyse && !phase_changed && overrun;
	assign track_fault = analyse && !phase_changed && !overrun &&
		bound_exceeded_flag;

	// Next tracking state; soft reset beats any pass
	always @* begin
		next_sensor_phase_sample = sensor_phase_sample;
		next_in_state_motion_count = in_state_motion_count;
		next_prev_in_state_position = prev_in_state_position;
		next_prev_step_value = prev_step_value;
		next_large_step_flag = large_step_flag;
		next_large_step_counter = large_step_counter;
		next_second_chance_flag = second_chance_flag;
		next_fault_status_word = fault_status_word;
		next_cmd_block = o_cmd_block;
		next_drive_shutdown = 1'b0;
		if (soft_reset) begin
			next_sensor_phase_sample = 1'b0; // R19
			next_in_state_motion_count = 16'h0000;
			next_prev_in_state_position = 16'h0000;
			next_prev_step_value = 16'h0000;
			next_large_step_flag = 1'b0;
			next_large_step_counter = 8'h00;
			next_second_chance_flag = 1'b0; // R19
			next_fault_status_word = `FAULT_RESET;
			next_cmd_block = 1'b0;
		end else if (analyse) begin
			next_sensor_phase_sample = phase_now; // R17
			if (phase_changed) begin
				next_in_state_motion_count = 16'h0000; // R1
			end else if (overrun) begin
				next_large_step_flag = 1'b1; // R4
				next_large_step_counter = next_large_count; // R12
				next_fault_status_word = fault_status_word |
					`OVERRUN_FAULT_BITS; // R13
				next_drive_shutdown = 1'b1; // R13
			end else begin
				if (step_small) begin
					next_large_step_flag = 1'b0; // R3
				end else begin
					next_large_step_flag = 1'b1; // R4
					next_large_step_counter = next_large_count; // R12
				end
				next_in_state_motion_count = next_motion_count; // R6
				next_prev_step_value = addend; // R7
				next_prev_in_state_position = current_position; // R8
				if (bound_exceeded_flag) begin
					next_fault_status_word = fault_status_word |
						`TRACK_FAULT_BITS; // R10
					next_second_chance_flag = 1'b1; // R11
					next_drive_shutdown = 1'b1; // R11
					if (second_chance_flag) begin
						next_cmd_block = 1'b1; // R18
					end
				end
			end
		end
	end

	// Sensor phase seen on the last analysed pass
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			sensor_phase_sample <= 1'b0; // R19
		end else begin
			sensor_phase_sample <= next_sensor_phase_sample; // R17
		end
	end

	// Motion accumulated within the current sensor state
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			in_state_motion_count <= 16'h0000; // R19
		end else begin
			in_state_motion_count <= next_in_state_motion_count; // R6
		end
	end

	// Previous in-state position sample
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			prev_in_state_position <= 16'h0000; // R19
		end else begin
			prev_in_state_position <= next_prev_in_state_position; // R8
		end
	end

	// Step kept as a substitute for a later large step
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			prev_step_value <= 16'h0000; // R19
		end else begin
			prev_step_value <= next_prev_step_value; // R7
		end
	end

	// Large-step flag of the last analysed pass
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			large_step_flag <= 1'b0; // R19
		end else begin
			large_step_flag <= next_large_step_flag; // R4
		end
	end

	// Large-step occurrences, wraps at 8 bits
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			large_step_counter <= 8'h00; // R19
		end else begin
			large_step_counter <= next_large_step_counter; // R12
		end
	end

	// Sticky second-chance flag, cleared only by a reset
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			second_chance_flag <= 1'b0; // R19
		end else begin
			second_chance_flag <= next_second_chance_flag; // R11
		end
	end

	// Command block after a repeated tracking failure
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			o_cmd_block <= 1'b0;
		end else begin
			o_cmd_block <= next_cmd_block; // R18
		end
	end

	// Fault status word, bits only ever merged in
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			fault_status_word <= `FAULT_RESET;
		end else begin
			fault_status_word <= next_fault_status_word; // R10 R13
		end
	end

	// One-cycle shutdown command on either fault
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			o_drive_shutdown <= 1'b0;
		end else begin
			o_drive_shutdown <= next_drive_shutdown; // R11 R13
		end
	end

	// Screw-ignore bit of the control register
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			screw_ignore_flag <= 1'b0;
		end else if (control_write) begin
			screw_ignore_flag <= i_wdata[`CTRL_SCREW_IGNORE]; // R16
		end
	end

	// Interrupt mask register
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_mask <= `IRQ_MASK_RESET;
		end else if (mask_write) begin
			irq_mask <= i_wdata[`IRQ_WIDTH-1:0];
		end
	end

	// Sticky event bits, write one to clear, a new event wins
	assign irq_events = {
		analyse && phase_changed,
		overrun_fault,
		analyse && !phase_changed && !step_small,
		track_fault
	};

	// One sticky flag per event bit, set beats a same-cycle clear
	genvar bit_index;
	generate
		for (bit_index = 0; bit_index < `IRQ_WIDTH;
			bit_index = bit_index + 1) begin : irq_bits
			reg sticky;
			always @(posedge i_clock or negedge reset_n) begin
				if (!reset_n) begin
					sticky <= 1'b0;
				end else if (irq_events[bit_index]) begin
					sticky <= 1'b1;
				end else if (irq_clear && i_wdata[bit_index]) begin
					sticky <= 1'b0;
				end
			end
			assign irq_status[bit_index] = sticky;
		end
	endgenerate

	assign o_irq = |(irq_status & irq_mask);

	// Read multiplexer; unmapped addresses read zero
	always @* begin
		next_rdata = 32'h00000000;
		case (i_addr)
		`REG_CONTROL: begin
			next_rdata[`CTRL_SCREW_IGNORE] = screw_ignore_flag;
		end
		`REG_STATE: begin
			next_rdata[`STATE_SECOND_CHANCE] = second_chance_flag;
			next_rdata[`STATE_LARGE_STEP] = large_step_flag;
			next_rdata[`STATE_CMD_BLOCK] = o_cmd_block;
		end
		`REG_FAULT_STATUS: begin
			next_rdata[15:0] = fault_status_word;
		end
		`REG_MOTION_COUNT: begin
			next_rdata[15:0] = in_state_motion_count;
		end
		`REG_LARGE_COUNT: begin
			next_rdata[7:0] = large_step_counter;
		end
		`REG_IRQ_STATUS: begin
			next_rdata[`IRQ_WIDTH-1:0] = irq_status;
		end
		`REG_IRQ_MASK: begin
			next_rdata[`IRQ_WIDTH-1:0] = irq_mask;
		end
		default: begin
			next_rdata = 32'h00000000;
		end
		endcase
	end

	// Read data stand one cycle after the strobe, zero otherwise
	always @(posedge i_clock or negedge reset_n) begin
		if (!reset_n) begin
			o_rdata <= 32'h00000000;
		end else if (i_read) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= 32'h00000000;
		end
	end

endmodule

// [bench/screw_monitor_asserts.sv]
/* Port checker for the second screw tracking monitor.
 Assumes binding onto the monitor top module. */
`timescale 1ns/1ps
module screw_monitor_asserts(
	input wire i_clock,
	input wire i_reset_n,
	input wire i_eval_pass,
	input wire [7:0] i_discretes,
	input wire [15:0] i_position,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_write,
	input wire i_read,
	input wire [31:0] o_rdata,
	input wire o_drive_shutdown,
	input wire o_cmd_block,
	input wire o_irq
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	// Soft reset write to control
	wire soft_wr = i_write && i_addr == 8'h00 && i_wdata[1];
	sequence block_gone;
		!o_cmd_block ##1 !o_cmd_block;
	endsequence
	chk_shutdown_cause: assert property (o_drive_shutdown
		|-> $past(i_eval_pass))
		else $error("shutdown without a pass");
	chk_shutdown_pulse: assert property (o_drive_shutdown
		&& !i_eval_pass |=> !o_drive_shutdown)
		else $error("shutdown too long");
	chk_block_cause: assert property ($rose(o_cmd_block) |->
		o_drive_shutdown && $past(i_eval_pass))
		else $error("block without fault pass");
	chk_block_sticky: assert property (o_cmd_block && !soft_wr
		|=> o_cmd_block) else $error("block dropped");
	chk_soft_clear: assert property (soft_wr |=> block_gone)
		else $error("block kept after soft reset");
	chk_rdata_idle: assert property (!$past(i_read) |-> o_rdata == 32'h0)
		else $error("read data outside slot");
	chk_unmapped_zero: assert property (i_read && i_addr == 8'h40
		|=> o_rdata == 32'h0) else $error("unmapped read not zero");
	chk_mask_quiet: assert property (i_write && i_addr == 8'h18
		&& i_wdata[3:0] == 4'h0 |=> !o_irq) else $error("irq while masked");
endmodule
bind second_screw_tracking_monitor screw_monitor_asserts
	u_screw_monitor_asserts(
	.i_clock(i_clock), .i_reset_n(i_reset_n), .i_eval_pass(i_eval_pass),
	.i_discretes(i_discretes), .i_position(i_position), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
	.o_rdata(o_rdata), .o_drive_shutdown(o_drive_shutdown),
	.o_cmd_block(o_cmd_block), .o_irq(o_irq));

// [bench/focus_sensor_model.sv]
/* Focus encoder and second screw sensor model.
 Assumes the bench pulses i_advance one cycle before each pass. */
`timescale 1ns/1ps
module focus_sensor_model(
	input wire logic i_clock,
	input wire logic i_advance,
	input wire logic signed [13:0] i_delta,
	input wire logic i_flip,
	output logic [15:0] o_position,
	output logic [7:0] o_discretes
);
	logic [13:0] native = 14'h0;
	logic phase = 1'b0;
	logic [7:0] noise = 8'h5a;
	// Native count shifted into the word, phase on its own bit
	assign o_position = {native, 2'b00};
	assign o_discretes = (noise & 8'hdf) | {2'b00, phase, 5'h0};
	// Move shaft, maybe toggle phase, churn the other bits
	always @(posedge i_clock) begin
		if (i_advance) begin
			native <= native + i_delta;
			phase <= phase ^ i_flip;
			noise <= noise + 8'h3b;
		end
	end
endmodule

// [bench/second_screw_tracking_monitor_test.sv]
/* Testbench for the second screw tracking monitor.
 Assumes the model and checker files are compiled first. */
`timescale 1ns/1ps
module second_screw_tracking_monitor_test;
	logic i_clock = 0, i_reset_n = 0, i_eval_pass = 0, i_write = 0;
	logic i_read = 0, adv = 0, fl = 0;
	logic [7:0] i_addr = 0, disc, lc;
	logic [31:0] i_wdata = 0, o_rdata, rv;
	logic [15:0] pos, flt;
	logic o_drive_shutdown, o_cmd_block, o_irq;
	logic signed [13:0] dl = 0;
	logic signed [15:0] cnt, sav, prv, st;
	logic ph, flag, sc, blk, sd, irq0, msk;
	integer fail_count = 0, total_checks = 0, cyc = 0, seed = 32'h680e, k;
	always #5 i_clock = ~i_clock;
	second_screw_tracking_monitor u_second_screw_tracking_monitor(
		.i_clock(i_clock), .i_reset_n(i_reset_n), .i_eval_pass(i_eval_pass),
		.i_discretes(disc), .i_position(pos), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
		.o_rdata(o_rdata), .o_drive_shutdown(o_drive_shutdown),
		.o_cmd_block(o_cmd_block), .o_irq(o_irq));
	focus_sensor_model u_focus_sensor_model(.i_clock(i_clock),
		.i_advance(adv), .i_delta(dl), .i_flip(fl),
		.o_position(pos), .o_discretes(disc));
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Hang guard
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			conclude;
		end
	end
	task cmp(input string n, input [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge i_clock);
		i_write <= 1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_write <= 0;
	endtask
	task rd(input [7:0] a);
		@(posedge i_clock);
		i_read <= 1;
		i_addr <= a;
		@(posedge i_clock);
		i_read <= 0;
		#1 rv = o_rdata;
	endtask
	task clr;
		{cnt, sav, prv, flt, lc, ph, flag, sc, blk} = '0;
	endtask
	task vfy;
		rd(8'h0c);
		cmp("count", {16'h0, cnt}, rv);
		rd(8'h08);
		cmp("fault", {16'h0, flt}, rv);
		rd(8'h10);
		cmp("large", {24'h0, lc}, rv);
		rd(8'h04);
		cmp("state", {29'h0, blk, flag, sc}, rv);
		cmp("block pin", {31'h0, blk}, {31'h0, o_cmd_block});
		cmp("irq", {31'h0, irq0 & msk}, {31'h0, o_irq});
	endtask
	// Reference pass behaviour
	task predict;
		sd = 0;
		if (disc[5] != ph) begin
			ph = disc[5];
			cnt = 0;
		end else begin
			st = sav - pos;
			if (st <= 12 && st >= -12) begin
				flag = 0;
				cnt = cnt + st;
				prv = st;
				sav = pos;
			end else begin
				flag = 1;
				lc = lc + 1;
				if (lc == 10) begin
					flt = flt | 16'h0a00;
					sd = 1;
				end else begin
					cnt = cnt + prv;
					sav = pos;
				end
			end
			if (!(flag && lc == 10) && (cnt >= 50 || cnt <= -50)) begin
				blk = blk | sc;
				flt = flt | 16'h8200;
				sc = 1;
				sd = 1;
				irq0 = 1;
			end
		end
	endtask
	task pass(input integer d, input bit f, input bit ign);
		@(posedge i_clock);
		adv <= 1;
		dl <= 14'(d);
		fl <= f;
		@(posedge i_clock);
		adv <= 0;
		i_eval_pass <= 1;
		@(posedge i_clock);
		i_eval_pass <= 0;
		sd = 0;
		if (!ign)
			predict;
		#1 cmp("shutdown", {31'h0, sd}, {31'h0, o_drive_shutdown});
		vfy;
	endtask
	// Main sequence
	initial begin
		repeat (4) @(posedge i_clock);
		i_reset_n <= 1;
		repeat (3) @(posedge i_clock);
		clr;
		irq0 = 0;
		msk = 1;
		vfy;
		rd(8'h40);
		cmp("unmapped", 32'h0, rv);
		wr(8'h18, 32'h1);
		// Steps of exactly 12 until the count trips twice
		for (k = 0; k < 6; k++)
			pass(-3, 0, 0);
		wr(8'h14, 32'h1);
		irq0 = 0;
		vfy;
		wr(8'h00, 32'h2);
		clr;
		vfy;
		// A large step, a smooth step, then ten large ones, the counter tripping on the ninth
		pass(-2, 0, 0);
		pass(-2, 0, 0);
		for (k = 0; k < 10; k++)
			pass(4, 0, 0);
		wr(8'h00, 32'h2);
		clr;
		wr(8'h00, 32'h1);
		pass(3, 1, 1);
		wr(8'h00, 32'h0);
		wr(8'h18, 32'h0);
		msk = 0;
		// Random steps with occasional phase changes
		for (k = 0; k < 80; k++)
			pass($random(seed) % 5, ($random(seed) & 7) == 0, 0);
		conclude;
	end
endmodule
